/* alarm_history_defines.vh */
// Purpose: Constants for the alarm history logger.
// Assumes: 40 MHz clock.
// Notes:   Header holds definitions only.
`ifndef ALARM_HISTORY_DEFINES_VH
`define ALARM_HISTORY_DEFINES_VH
`define LOG_DEPTH          10
`define LOG_INDEX_W        4
`define ALARM_W            12
`define STAMP_W            32
`define CLOCK_HZ           40000000
`define TICK_MS            100
`define TICK_CYCLES        ((`CLOCK_HZ / 1000) * `TICK_MS)
`define HOUR_MS            3600000
`define HOUR_TICKS         (`HOUR_MS / `TICK_MS)
`define EMPTY_ALARM        12'hfff
`define EXEC_IDLE          2'h0
`define EXEC_PANEL         2'h1
`define EXEC_TOOL          2'h2
`endif

/* alarm_history_logger.v */
// Purpose: Ten-deep alarm history with operating-time stamps.
// Assumes: Storage flops sit on a backed-up supply; reset_n is power-on only.
// Notes:   Alarm reset is not an input here and never touches the log.
`timescale 1ns/10ps
`include "alarm_history_defines.vh"
module alarm_history_logger #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter HOUR_TICKS  = `HOUR_TICKS
) (
   input  wire                    clock,
   input  wire                    reset_n,
   input  wire                    control_power_on,
   input  wire                    main_power_on,
   input  wire                    alarm_raise,
   input  wire [`ALARM_W-1:0]     alarm_number,
   input  wire                    panel_request,
   input  wire                    tool_request,
   input  wire                    history_view_function,
   input  wire                    history_clear_function,
   input  wire [`LOG_INDEX_W-1:0] read_index,
   output reg  [`ALARM_W-1:0]     read_alarm,
   output reg  [`STAMP_W-1:0]     read_stamp,
   output reg                     read_valid,
   output reg                     read_done,
   output reg                     clear_done,
   output reg                     conflict_no_operation_indication,
   output reg  [`STAMP_W-1:0]     operating_time
);

   reg [`ALARM_W-1:0]     log_alarm [0:`LOG_DEPTH-1];
   reg [`STAMP_W-1:0]     log_stamp [0:`LOG_DEPTH-1];
   reg [`LOG_DEPTH-1:0]   log_used;
   reg [31:0]             tick_count;
   wire [`LOG_DEPTH-1:0]  slot_hit;
   wire                   recent_hit;
   wire                   granted;
   wire                   view_now;
   wire                   conflict;
   wire                   log_alarm_now;
   wire                   clear_now;
   integer                k;
   genvar                 s;

   ////////////////////////////////////////////////////////////////////////////
   // Exactly one executor may own a utility function in a given cycle.
   function single_request;
      input panel;
      input tool;
      begin
         single_request = panel ^ tool;
      end
   endfunction

   // The subtraction wraps, so the age stays correct across a counter wrap.
   function slot_is_recent;
      input [`STAMP_W-1:0] now;
      input [`STAMP_W-1:0] stamp;
      reg   [`STAMP_W-1:0] age;
      begin
         age            = now - stamp;
         slot_is_recent = (age <= HOUR_TICKS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Operating time. Ticks only while both supplies are up, so the stamp
   // counts powered time rather than wall time.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_count     <= 32'h0;
         operating_time <= {`STAMP_W{1'b0}};
      end else if (control_power_on && main_power_on) begin
         if (tick_count == TICK_CYCLES - 1) begin
            tick_count     <= 32'h0;
            operating_time <= operating_time + 1'b1;
         end else begin
            tick_count <= tick_count + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Repeat filter. Any matching entry at most one hour old blocks the new one.
   generate
      for (s = 0; s < `LOG_DEPTH; s = s + 1) begin : g_filter
         assign slot_hit[s] = log_used[s] && (log_alarm[s] == alarm_number) &&
                              slot_is_recent(operating_time, log_stamp[s]);
      end
   endgenerate

   assign recent_hit = |slot_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Executor arbitration. Both executors at once get refused outright.
   assign conflict      = panel_request && tool_request;
   assign granted       = single_request(panel_request, tool_request);
   assign clear_now     = granted && history_clear_function;
   assign view_now      = granted && history_view_function;
   assign log_alarm_now = alarm_raise && !recent_hit;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         conflict_no_operation_indication <= 1'b0;
      end else begin
         conflict_no_operation_indication <= conflict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Log storage as a shift register: slot 0 is always the newest. A clear in
   // the same cycle as an alarm still keeps that alarm so it is not lost.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         log_used <= {`LOG_DEPTH{1'b0}};
         for (k = 0; k < `LOG_DEPTH; k = k + 1) begin
            log_alarm[k] <= `EMPTY_ALARM;
            log_stamp[k] <= {`STAMP_W{1'b0}};
         end
      end else if (log_alarm_now) begin
         log_alarm[0] <= alarm_number;
         log_stamp[0] <= operating_time;
         log_used[0]  <= 1'b1;
         for (k = 1; k < `LOG_DEPTH; k = k + 1) begin
            log_alarm[k] <= log_alarm[k-1];
            log_stamp[k] <= log_stamp[k-1];
            log_used[k]  <= clear_now ? 1'b0 : log_used[k-1];
         end
      end else if (clear_now) begin
         log_used <= {`LOG_DEPTH{1'b0}};
         for (k = 0; k < `LOG_DEPTH; k = k + 1) begin
            log_alarm[k] <= `EMPTY_ALARM;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readout, registered one cycle after a granted view request.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         read_alarm <= `EMPTY_ALARM;
         read_stamp <= {`STAMP_W{1'b0}};
         read_valid <= 1'b0;
         read_done  <= 1'b0;
         clear_done <= 1'b0;
      end else begin
         read_done  <= 1'b0;
         clear_done <= clear_now;
         if (view_now) begin
            read_done <= 1'b1;
            if (read_index < `LOG_DEPTH && log_used[read_index]) begin
               read_alarm <= log_alarm[read_index];
               read_stamp <= log_stamp[read_index];
               read_valid <= 1'b1;
            end else begin
               read_alarm <= `EMPTY_ALARM;
               read_stamp <= {`STAMP_W{1'b0}};
               read_valid <= 1'b0;
            end
         end
      end
   end

endmodule

/* alarm_history_checker_assertions.sv */
// Purpose: Port assertions for the alarm history logger.
// Assumes: One clock and an active-low reset.
// Notes: Attached by the bind below.
`timescale 1ns/10ps
module alarm_history_checker (input wire clock, reset_n, main_power_on,
   input wire panel_request, tool_request, history_view_function, history_clear_function,
   input wire read_valid, read_done, clear_done, conflict_no_operation_indication,
   input wire [11:0] read_alarm, input wire [31:0] read_stamp, operating_time);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence one_req; panel_request ^ tool_request; endsequence
   AST_CONFLICT: assert property (panel_request && tool_request |=>
      conflict_no_operation_indication) else $error("conflict");
   AST_READ: assert property (one_req ##0 history_view_function |=> read_done)
      else $error("read");
   AST_READ_SRC: assert property (read_done |-> $past(panel_request ^ tool_request))
      else $error("read src");
   AST_CLEAR: assert property (one_req ##0 history_clear_function |=> clear_done)
      else $error("clear");
   AST_CLEAR_SRC: assert property (clear_done |-> $past(panel_request ^ tool_request))
      else $error("clear src");
   AST_EMPTY: assert property (read_done && !read_valid |-> read_alarm == 12'hfff
      && read_stamp == 32'h0) else $error("empty");
   AST_HOLD: assert property (!main_power_on |=> $stable(operating_time))
      else $error("hold");
   AST_STEP: assert property ($changed(operating_time) |-> operating_time ==
      $past(operating_time) + 32'h1 ##1 $stable(operating_time) [*3]) else $error("step");
endmodule
bind alarm_history_logger alarm_history_checker u_chk (.*);

/* executor_model.sv */
// Purpose: Panel and PC tool model.
// Assumes: Requests launch on the bench clock.
// Notes: Both executors at once only when asked.
`timescale 1ns/10ps
module executor_model (input wire clock, output reg panel_request = 1'b0,
   output reg tool_request = 1'b0, history_view_function = 1'b0,
   output reg history_clear_function = 1'b0, output reg [3:0] read_index = 4'h0);
   task run(input [1:0] who, input v, c, input [3:0] i);
      @(posedge clock);
      {tool_request, panel_request} <= who;
      {history_view_function, history_clear_function, read_index} <= {v, c, i};
      @(posedge clock);
      {tool_request, panel_request, history_view_function, history_clear_function} <= 4'h0;
      read_index <= ~i;
   endtask
endmodule

/* alarm_history_logger_tb.sv */
// Purpose: Self-checking bench for the alarm history logger.
// Assumes: Tick cut to 4 cycles and hour to 5 ticks.
// Notes: Power stays off at the end, so stamps need no restart model.
`timescale 1ns/10ps
module alarm_history_logger_tb;
   localparam TK = 4, HR = 5;
   reg clock = 1'b0, reset_n = 1'b0, alarm_raise = 1'b0, control_power_on = 1'b1;
   reg main_power_on = 1'b1;
   reg [11:0] alarm_number = 12'h000;
   wire panel_request, tool_request, history_view_function, history_clear_function;
   wire read_valid, read_done, clear_done, conflict_no_operation_indication;
   wire [3:0] read_index;
   wire [11:0] read_alarm;
   wire [31:0] read_stamp, operating_time;
   wire [44:0] got = {read_valid, read_alarm, read_stamp};
   integer fails = 0, checks = 0, seed = 67, cyc = 0, i, j, k, keep;
   reg [44:0] exp;
   reg [43:0] q[$];
   alarm_history_logger #(.TICK_CYCLES(TK), .HOUR_TICKS(HR)) DUT (.*);
   executor_model u_exec (.*);
   always #12.5 clock = ~clock;
   always @(posedge clock) if (reset_n && control_power_on && main_power_on) cyc <= cyc + 1;
   ////////////////////////////////////////
   task chk(input [44:0] g, input [44:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rd_all;
      for (k = 0; k < 11; k++) begin
         u_exec.run(2'h1 + k[0], 1'b1, 1'b0, k[3:0]);
         #1 exp = k < q.size() ? {1'b1, q[k]} : {1'b0, 12'hfff, 32'h0};
         checks++;
         if (got !== exp) fails++;
         if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         chk({read_done, clear_done, conflict_no_operation_indication}, 45'h4);
      end
      chk(operating_time, 32'(cyc / TK));
      $display("test done at %0t", $time);
   endtask
   task raise(input [11:0] n);
      @(posedge clock);
      {alarm_raise, alarm_number} <= {1'b1, n};
      #1 keep = 1;
      for (j = 0; j < q.size(); j++)
         if (q[j][43:32] == n && cyc / TK - q[j][31:0] <= HR) keep = 0;
      if (keep) q.push_front({n, 32'(cyc / TK)});
      if (q.size() > 10) q = q[0:9];
      @(posedge clock);
      alarm_raise <= 1'b0;
   endtask
   task results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rd_all;
      for (i = 0; i < 30; i++) raise(i[0] ? 12'h0c5 : {i[4:1], 8'($random(seed))});
      @(posedge clock) main_power_on <= 1'b0;
      rd_all;
      u_exec.run(2'h3, 1'b0, 1'b1, 4'h0);
      #1 chk({read_done, clear_done, conflict_no_operation_indication}, 45'h1);
      rd_all;
      u_exec.run(2'h2, 1'b0, 1'b1, 4'h0);
      #1 chk({read_done, clear_done, conflict_no_operation_indication}, 45'h2);
      q.delete();
      rd_all;
      results;
   end
endmodule
